// ### rtl/frs_device.sv
// flash rewrite sequencer: control registers, protection, suspend handling
`timescale 1ns/1ns
`include "frs_cfg.svh"
module frs_device
  import frs_pkg::*;
#(
  parameter int SETTLE_CYC = `FRS_SETTLE_CYC,
  parameter int BUSY_CYC = `FRS_BUSY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  frs_link_if.dev link,
  input wire logic fail_in,
  input wire logic sleep_in,
  output logic flash_power_out,
  output logic flash_access_ok_out
);
  logic ena_q, unlock_q, stop_q, perr_q, eerr_q;
  logic inplace_q, lock0_q, lock1_q;
  logic susp_en_q, erq_q, prq_q;
  logic [7:0] rdata_q;
  logic irq_ack_q, pwr_q, acc_q;
  frs_state_e st_q;
  frs_op_e op_q;
  logic [15:0] work_q;
  logic settle_start, settle_done;
  logic wr_a, wr_b, wr_s, wr_c;
  logic [7:0] reg_a, reg_b, reg_s;
  logic cmd_ok, busy, req_now;

  function automatic logic blk_ok(input logic blk, input logic unl,
                                  input logic l0, input logic l1);
    blk_ok = unl && !(blk ? l1 : l0);
  endfunction

  assign wr_a = link.wr && link.addr == `FRS_REG_CTRL_A;
  assign wr_b = link.wr && link.addr == `FRS_REG_CTRL_B;
  assign wr_s = link.wr && link.addr == `FRS_REG_SUSP;
  assign wr_c = link.wr && link.addr == `FRS_REG_CMD;
  assign busy = (st_q != FRS_ST_IDLE) && (st_q != FRS_ST_STOP);
  // commands need enable, no stop, idle, and the block unprotected
  assign cmd_ok = wr_c && ena_q && !stop_q && st_q == FRS_ST_IDLE &&
    (link.wdata[1:0] == 2'h1 || link.wdata[1:0] == 2'h2) &&
    blk_ok(link.wdata[2], unlock_q, lock0_q, lock1_q);
  // current suspend request: by software bit, or by irq in place
  assign req_now = susp_en_q && (op_q == FRS_OP_ERASE ? erq_q : prq_q);

  always_comb begin
    reg_a = 8'h00;
    reg_a[`FRS_A_READY] = !busy;
    reg_a[`FRS_A_ENABLE] = ena_q;
    reg_a[`FRS_A_UNLOCK] = unlock_q;
    reg_a[`FRS_A_STOP] = stop_q;
    reg_a[`FRS_A_PERR] = perr_q;
    reg_a[`FRS_A_EERR] = eerr_q;
    reg_b = 8'h00;
    reg_b[`FRS_B_INPLACE] = inplace_q;
    reg_b[`FRS_B_LOCK0] = lock0_q;
    reg_b[`FRS_B_LOCK1] = lock1_q;
    reg_s = 8'h00;
    reg_s[`FRS_S_EN] = susp_en_q;
    reg_s[`FRS_S_ERQ] = erq_q;
    reg_s[`FRS_S_PRQ] = prq_q;
    reg_s[`FRS_S_EACT] = busy && op_q == FRS_OP_ERASE;
    reg_s[`FRS_S_PACT] = busy && op_q == FRS_OP_PROG;
    reg_s[`FRS_S_RDOK] = st_q == FRS_ST_SUSP;
  end

  frs_settle_timer #(.CYCLES(SETTLE_CYC)) u_settle (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(settle_start),
    .done_out(settle_done)
  );
  assign settle_start = cmd_ok || (st_q == FRS_ST_RUN && req_now && !inplace_q);

  // control register a and b
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ena_q <= 1'b0;
      unlock_q <= 1'b0;
      stop_q <= 1'b0;
      inplace_q <= 1'b0;
      lock0_q <= 1'b1;
      lock1_q <= 1'b1;
    end else if (ce_in) begin
      if (wr_a) begin
        ena_q <= link.wdata[`FRS_A_ENABLE];
        unlock_q <= link.wdata[`FRS_A_ENABLE] && link.wdata[`FRS_A_UNLOCK];
        stop_q <= link.wdata[`FRS_A_STOP];
        if (!link.wdata[`FRS_A_ENABLE]) begin
          inplace_q <= 1'b0;
        end
      end
      if (wr_b && ena_q) begin
        inplace_q <= link.wdata[`FRS_B_INPLACE];
        lock0_q <= link.wdata[`FRS_B_LOCK0];
        lock1_q <= link.wdata[`FRS_B_LOCK1];
      end
    end
  end

  // suspend register; in-place irq sets the request bit itself
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      susp_en_q <= 1'b0;
      erq_q <= 1'b0;
      prq_q <= 1'b0;
    end else if (ce_in) begin
      if (wr_s) begin
        susp_en_q <= link.wdata[`FRS_S_EN];
      end
      if (!busy || stop_q) begin
        erq_q <= 1'b0;
        prq_q <= 1'b0;
      end else if (inplace_q && susp_en_q && link.irq && st_q == FRS_ST_RUN
                   && settle_done) begin
        erq_q <= erq_q || op_q == FRS_OP_ERASE;
        prq_q <= prq_q || op_q == FRS_OP_PROG;
      end else if (wr_s) begin
        // in place software may only clear; ram-run may set or clear
        erq_q <= link.wdata[`FRS_S_ERQ] && op_q == FRS_OP_ERASE &&
          (!inplace_q || erq_q);
        prq_q <= link.wdata[`FRS_S_PRQ] && op_q == FRS_OP_PROG &&
          (!inplace_q || prq_q);
      end
    end
  end

  // sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= FRS_ST_IDLE;
      op_q <= FRS_OP_NONE;
      work_q <= 16'h0000;
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
    end else if (ce_in) begin
      if (wr_c && link.wdata[`FRS_C_CLR]) begin
        perr_q <= 1'b0;
        eerr_q <= 1'b0;
      end
      case (st_q)
        FRS_ST_IDLE: begin
          if (stop_q) begin
            st_q <= FRS_ST_STOP;
          end else if (cmd_ok) begin
            st_q <= FRS_ST_RUN;
            op_q <= frs_op_e'(link.wdata[1:0]);
            work_q <= 16'(BUSY_CYC);
          end
        end
        FRS_ST_RUN: begin
          if (stop_q) begin
            st_q <= FRS_ST_STOP;
          end else if (req_now) begin
            st_q <= FRS_ST_SETTLE;
          end else if (work_q <= 16'h0001) begin
            st_q <= FRS_ST_IDLE;
            // placed after the clear above, so a failing end beats a clear
            if (fail_in && op_q == FRS_OP_PROG) begin
              perr_q <= 1'b1;
            end
            if (fail_in && op_q == FRS_OP_ERASE) begin
              eerr_q <= 1'b1;
            end
            op_q <= FRS_OP_NONE;
          end else begin
            work_q <= work_q - 16'h0001;
          end
        end
        FRS_ST_SETTLE: begin
          if (stop_q) begin
            st_q <= FRS_ST_STOP;
          end else if (!req_now) begin
            st_q <= FRS_ST_RUN;
          end else if (settle_done) begin
            st_q <= FRS_ST_SUSP;
          end
        end
        FRS_ST_SUSP: begin
          if (stop_q) begin
            st_q <= FRS_ST_STOP;
          end else if (!req_now) begin
            st_q <= FRS_ST_RUN;
          end
        end
        FRS_ST_STOP: begin
          op_q <= FRS_OP_NONE;
          if (!stop_q) begin
            st_q <= FRS_ST_IDLE;
          end
        end
        default: st_q <= FRS_ST_IDLE;
      endcase
    end
  end

  // outputs: read data, irq acknowledge, power, access
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
      irq_ack_q <= 1'b0;
      pwr_q <= 1'b1;
      acc_q <= 1'b1;
    end else if (ce_in) begin
      rdata_q <= 8'h00;
      if (link.rd) begin
        case (link.addr)
          `FRS_REG_CTRL_A: rdata_q <= reg_a;
          `FRS_REG_CTRL_B: rdata_q <= reg_b;
          `FRS_REG_SUSP: rdata_q <= reg_s;
          default: rdata_q <= 8'h00;
        endcase
      end
      // in place with suspend enabled the irq waits for the settle delay after the command
      irq_ack_q <= link.irq && !irq_ack_q &&
        (!inplace_q || !busy || !susp_en_q || settle_done);
      pwr_q <= !(stop_q && ena_q) && !(sleep_in && !ena_q);
      acc_q <= !stop_q && (!busy || st_q == FRS_ST_SUSP);
    end
  end
  assign link.rdata = rdata_q;
  assign link.irq_ack = irq_ack_q;
  assign flash_power_out = pwr_q;
  assign flash_access_ok_out = acc_q;
endmodule

// ### rtl/frs_cfg.svh
// constants for the flash rewrite and suspend controller
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH
`define FRS_CLK_MHZ 20
`define FRS_SETTLE_NS 2000
`define FRS_SETTLE_CYC ((`FRS_SETTLE_NS * `FRS_CLK_MHZ + 999) / 1000)
`define FRS_BUSY_CYC 64
// software register offsets
`define FRS_REG_CTRL_A 4'h0
`define FRS_REG_CTRL_B 4'h1
`define FRS_REG_SUSP 4'h2
`define FRS_REG_CMD 4'h3
// control register a fields
`define FRS_A_READY 0
`define FRS_A_ENABLE 1
`define FRS_A_UNLOCK 2
`define FRS_A_STOP 3
`define FRS_A_PERR 6
`define FRS_A_EERR 7
// control register b fields
`define FRS_B_INPLACE 1
`define FRS_B_LOCK0 5
`define FRS_B_LOCK1 6
// suspend register fields
`define FRS_S_EN 0
`define FRS_S_ERQ 1
`define FRS_S_PRQ 2
`define FRS_S_EACT 3
`define FRS_S_PACT 4
`define FRS_S_RDOK 6
// command register fields: [1:0] op, [2] block, [3] clear status
`define FRS_C_CLR 3
`endif

// ### rtl/frs_pkg.sv
// types shared by both ends of the flash rewrite controller
package frs_pkg;
  typedef enum logic [1:0] {
    FRS_OP_NONE,
    FRS_OP_PROG,
    FRS_OP_ERASE
  } frs_op_e;
  typedef enum logic [2:0] {
    FRS_ST_IDLE,
    FRS_ST_RUN,
    FRS_ST_SETTLE,
    FRS_ST_SUSP,
    FRS_ST_STOP
  } frs_state_e;
endpackage

// ### rtl/frs_link_if.sv
// link between the software side controller and the flash sequencer
`timescale 1ns/1ns
interface frs_link_if;
  import frs_pkg::*;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic irq_ack;
  modport dev (
    input addr, wdata, wr, rd, irq,
    output rdata, irq_ack
  );
  modport cpu (
    output addr, wdata, wr, rd, irq,
    input rdata, irq_ack
  );
endinterface

// ### rtl/frs_settle_timer.sv
// down counter giving the suspend settle delay
`timescale 1ns/1ns
module frs_settle_timer #(
  parameter int CYCLES = 40
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  output logic done_out
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 16'h0000;
    end else if (ce_in) begin
      if (start_in) begin
        cnt_q <= 16'(CYCLES);
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
  assign done_out = (cnt_q == 16'h0000) && !start_in;
endmodule

// ### rtl/frs_cpu.sv
// software side end: forwards register port and interrupt to the link
`timescale 1ns/1ns
`include "frs_cfg.svh"
module frs_cpu
  import frs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  frs_link_if.cpu link,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic irq_in,
  output logic [7:0] rdata_out,
  output logic irq_taken_out,
  output logic ready_out
);
  logic rd_a_q;
  logic taken_q, ready_q, irq_q;
  assign link.addr = addr_in;
  assign link.wdata = wdata_in;
  assign link.wr = wr_in && ce_in;
  assign link.rd = rd_in && ce_in;
  assign link.irq = irq_q;
  // irq held until acknowledged; ready mirrored from polls, no status command
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
      taken_q <= 1'b0;
      rd_a_q <= 1'b0;
      ready_q <= 1'b1;
    end else if (ce_in) begin
      taken_q <= link.irq_ack;
      if (link.irq_ack) begin
        irq_q <= 1'b0;
      end else if (irq_in) begin
        irq_q <= 1'b1;
      end
      rd_a_q <= rd_in && addr_in == `FRS_REG_CTRL_A;
      if (rd_a_q) begin
        ready_q <= link.rdata[`FRS_A_READY];
      end
    end
  end
  assign rdata_out = link.rdata;
  assign irq_taken_out = taken_q;
  assign ready_out = ready_q;
endmodule

// ### bench/frs_asserts.sv
// checker on the link between the two ends
`timescale 1ns/1ns
module frs_asserts #(
  parameter int SETTLE_CYC = 40
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic irq_ack
);
  // ack may wait out the settle delay counted from the command
  localparam int ACK_MAX = SETTLE_CYC + 8;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  idle_rdata_zero_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without a read");
  unmapped_zero_a: assert property (rd && addr > 4'h3 |=> rdata == 8'h00)
    else $error("unmapped read gave data");
  ack_one_cycle_a: assert property (irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");
  ack_has_cause_a: assert property (irq_ack |-> $past(irq))
    else $error("ack without request");
  ack_bounded_a: assert property ($rose(irq) |-> ##[1:ACK_MAX] irq_ack)
    else $error("ack never came");
  permit_needs_en_a: assert property (rd && addr == 4'h2 |=> !rdata[6] || rdata[0])
    else $error("read permit without suspend enable");
  permit_when_busy_a: assert property (
    rd && addr == 4'h2 |=> !rdata[6] || rdata[3] || rdata[4])
    else $error("read permit while idle");
  one_op_active_a: assert property (rd && addr == 4'h2 |=> !(rdata[3] && rdata[4]))
    else $error("both operations active");
  enable_readback_a: assert property (
    wr && addr == 4'h0 ##1 rd && addr == 4'h0 |=> rdata[1] == $past(wdata[1], 2))
    else $error("enable bit not kept");
endmodule

// ### bench/test_flash_rewrite_suspend_ctrl.sv
// self-checking bench for both ends of the flash rewrite controller
`timescale 1ns/1ns
module test_flash_rewrite_suspend_ctrl;
  localparam int SETTLE = 4;
  localparam int BUSY = 40;
  logic clk_in = 1'b0, rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic wr = 1'b0, rd = 1'b0, irq = 1'b0, fail = 1'b0, sleep = 1'b0;
  logic irq_taken, ready, power, access_ok;
  int bad_count = 0, checks = 0;
  frs_link_if link ();
  frs_device #(.SETTLE_CYC(SETTLE), .BUSY_CYC(BUSY)) frs_device_inst (.clk_in(clk_in),
    .rst_in(rst_in), .ce_in(1'b1), .link(link), .fail_in(fail), .sleep_in(sleep),
    .flash_power_out(power), .flash_access_ok_out(access_ok));
  frs_cpu frs_cpu_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .link(link),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .irq_in(irq),
    .rdata_out(rdata), .irq_taken_out(irq_taken), .ready_out(ready));
  frs_asserts #(.SETTLE_CYC(SETTLE)) frs_asserts_inst (.clk_in(clk_in), .rst_in(rst_in),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .irq(link.irq), .irq_ack(link.irq_ack));
  always #25 clk_in = ~clk_in;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // the #1 keeps back-to-back strobes in separate time steps
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
    check(v & m, e);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    v = 8'h00;
    while (v[0] !== 1'b1 && n < 200) begin
      rd_chk(4'h0, 8'h02, 8'h02);
      n++;
    end
    cycles(1);
    check({6'h00, ready, v[0]}, 8'h03);
  endtask
  task automatic t_reset();
    rd_chk(4'h0, 8'hff, 8'h01);
    rd_chk(4'h1, 8'hff, 8'h60);
    rd_chk(4'h2, 8'hff, 8'h00);
    rd_chk(4'h9, 8'hff, 8'h00);
    wr_reg(4'h1, 8'h02);
    rd_chk(4'h1, 8'hff, 8'h60);
    check({6'h00, power, access_ok}, 8'h03);
  endtask
  task automatic t_protect();
    wr_reg(4'h0, 8'h02);
    rd_chk(4'h0, 8'hff, 8'h03);
    wr_reg(4'h3, 8'h02);
    rd_chk(4'h2, 8'hff, 8'h00);
    wr_reg(4'h0, 8'h06);
    wr_reg(4'h3, 8'h02);
    rd_chk(4'h2, 8'hff, 8'h00);
    wr_reg(4'h1, 8'h40);
    wr_reg(4'h3, 8'h06);
    rd_chk(4'h2, 8'hff, 8'h00);
    wr_reg(4'h3, 8'h02);
    rd_chk(4'h2, 8'hff, 8'h08);
    rd_chk(4'h0, 8'hff, 8'h06);
    wait_ready();
    rd_chk(4'h2, 8'hff, 8'h00);
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h3, 8'h05);
    rd_chk(4'h2, 8'hff, 8'h10);
    wait_ready();
  endtask
  task automatic t_ram(input logic [7:0] cmd, input logic [7:0] req, input logic [7:0] act);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h3, cmd);
    wr_reg(4'h2, req);
    cycles(SETTLE + 2);
    rd_chk(4'h2, 8'h58, act);
    wr_reg(4'h2, req | 8'h01);
    cycles(SETTLE + 2);
    rd_chk(4'h2, 8'hff, act | req | 8'h41);
    rd_chk(4'h0, 8'h01, 8'h00);
    wr_reg(4'h2, 8'h01);
    // the sequencer leaves suspend one cycle after the clear
    cycles(1);
    rd_chk(4'h2, 8'h5f, act | 8'h01);
    wait_ready();
    rd_chk(4'h2, 8'h58, 8'h00);
  endtask
  task automatic t_inplace(input logic [7:0] cmd, input logic [7:0] req, input logic [7:0] act);
    int n;
    n = 0;
    wr_reg(4'h2, 8'h01);
    wr_reg(4'h3, cmd);
    irq <= 1'b1;
    cycles(1);
    irq <= 1'b0;
    while (irq_taken !== 1'b1 && n < 50) begin
      cycles(1);
      n++;
    end
    check({7'h00, n > SETTLE && n < SETTLE + 4}, 8'h01);
    cycles(SETTLE + 2);
    rd_chk(4'h2, 8'hff, act | req | 8'h41);
    rd_chk(4'h0, 8'h01, 8'h00);
    wr_reg(4'h2, 8'h01);
    cycles(1);
    rd_chk(4'h2, 8'h5f, act | 8'h01);
    wait_ready();
  endtask
  task automatic t_errors();
    fail <= 1'b1;
    wr_reg(4'h3, 8'h01);
    wait_ready();
    rd_chk(4'h0, 8'hc1, 8'h41);
    wr_reg(4'h3, 8'h02);
    wait_ready();
    rd_chk(4'h0, 8'hc1, 8'hc1);
    fail <= 1'b0;
    wr_reg(4'h3, 8'h08);
    rd_chk(4'h0, 8'hc1, 8'h01);
    wr_reg(4'h0, 8'hc6);
    rd_chk(4'h0, 8'hff, 8'h07);
  endtask
  task automatic t_stop();
    wr_reg(4'h0, 8'h0e);
    cycles(1);
    check({6'h00, power, access_ok}, 8'h00);
    wr_reg(4'h3, 8'h02);
    rd_chk(4'h2, 8'h18, 8'h00);
    wr_reg(4'h0, 8'h06);
    cycles(1);
    check({6'h00, power, access_ok}, 8'h03);
    wr_reg(4'h0, 8'h00);
    sleep <= 1'b1;
    cycles(2);
    check({7'h00, power}, 8'h00);
    sleep <= 1'b0;
    cycles(2);
    check({7'h00, power}, 8'h01);
  endtask
  task automatic t_mode();
    wr_reg(4'h1, 8'h02);
    rd_chk(4'h1, 8'hff, 8'h02);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    cycles(1);
    t_reset();
    t_protect();
    t_ram(8'h01, 8'h04, 8'h10);
    t_ram(8'h02, 8'h02, 8'h08);
    t_mode();
    t_inplace(8'h01, 8'h04, 8'h10);
    t_inplace(8'h02, 8'h02, 8'h08);
    t_errors();
    t_stop();
    final_report();
  end
  // the whole run needs under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule
